// ### hdl/cma_arb_top.sv
// two arbitration word sets with apb access and handler decisions
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module cma_arb_top (
   input  wire logic                                      pclk,
   input  wire logic                                      presetn,
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [31:0]                               paddr,
   input  wire logic [31:0]                               pwdata,
   output logic [31:0]                                    prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   input  wire logic [cma_pkg::NUM_SETS-1:0]              ram_load,
   input  wire cma_pkg::cma_arb_t [cma_pkg::NUM_SETS-1:0] ram_word,
   input  wire logic [cma_pkg::NUM_SETS-1:0][15:0]        tag_lower,
   input  wire logic [cma_pkg::NUM_SETS-1:0]              send_pending_flag,
   input  wire logic [cma_pkg::NUM_SETS-1:0]              auto_answer_enable,
   input  wire cma_pkg::cma_rx_t                          rx_frame,
   output cma_pkg::cma_arb_t [cma_pkg::NUM_SETS-1:0]      arb_to_ram,
   output logic [cma_pkg::NUM_SETS-1:0][28:0]             object_tag,
   output logic [cma_pkg::NUM_SETS-1:0]                   object_active,
   output cma_pkg::cma_act_t [cma_pkg::NUM_SETS-1:0]      handler_act
);
   import cma_pkg::*;

   //------------------------------------------------------------
   // declarations
   //------------------------------------------------------------
   cma_arb_t [NUM_SETS-1:0]            word;
   logic [NUM_SETS-1:0]                hit;
   logic [NUM_SETS-1:0]                bus_we;
   logic                               access;
   logic                               done;
   logic                               mapped;
   logic [31:0]                        next_prdata;
   logic                               next_pready;
   logic                               next_pslverr;
   cma_arb_t [NUM_SETS-1:0]            next_arb_to_ram;
   logic [NUM_SETS-1:0][ID_W-1:0]      next_object_tag;
   logic [NUM_SETS-1:0]                next_object_active;
   cma_act_t [NUM_SETS-1:0]            next_handler_act;
   logic [NUM_SETS-1:0]                tag_match;

   //------------------------------------------------------------
   // apb decode
   //------------------------------------------------------------
   assign hit[0] = (paddr == ADDR_IF1_ARB2);
   assign hit[1] = (paddr == ADDR_IF2_ARB2);
   assign mapped = |hit;
   assign access = psel & penable;
   // one wait state keeps every bus output straight from a flop
   assign done   = access & pready;

   always_comb begin
      next_pready  = access & ~pready;
      next_prdata  = RDATA_IDLE;
      next_pslverr = 1'b0;
      if (access && !pready) begin
         next_pslverr = ~mapped;
         for (int i = 0; i < NUM_SETS; i++) begin
            if (hit[i] && !pwrite) begin
               // upper half reads as zero
               next_prdata = {16'h0000, word[i]};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= RDATA_IDLE;
         pslverr <= 1'b0;
      end else begin
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   //------------------------------------------------------------
   // register sets
   //------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_SETS; g++) begin : g_set
         assign bus_we[g] = done & pwrite & hit[g];

         cma_arb_word u_word (
            .pclk     (pclk),
            .presetn  (presetn),
            .bus_we   (bus_we[g]),
            .bus_data (cma_arb_t'(pwdata[WORD_W-1:0])),
            .ram_we   (ram_load[g]),
            .ram_data (ram_word[g]),
            .word     (word[g])
         );
      end
   endgenerate

   //------------------------------------------------------------
   // identifier compare
   //------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_SETS; i++) begin
         tag_match[i] = 1'b0;
         if (rx_frame.long_tag == word[i].long_tag_select) begin
            if (word[i].long_tag_select) begin
               tag_match[i] = (rx_frame.tag == {word[i].arbitration_tag_upper, tag_lower[i]});
            end else begin
               tag_match[i] = (rx_frame.tag[ID_W-1:ID_W-11]
                               == word[i].arbitration_tag_upper[TAG_W-1:STD_SHIFT]);
            end
         end
      end
   end

   //------------------------------------------------------------
   // handler decisions
   //------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NUM_SETS; i++) begin
         next_handler_act[i] = '0;
         next_arb_to_ram[i]  = word[i];
         next_object_active[i] = word[i].object_in_use_flag;
         if (word[i].long_tag_select) begin
            next_object_tag[i] = {word[i].arbitration_tag_upper, tag_lower[i]};
         end else begin
            next_object_tag[i] = {word[i].arbitration_tag_upper[TAG_W-1:STD_SHIFT], 18'h00000};
         end
         if (word[i].object_in_use_flag) begin
            if (send_pending_flag[i]) begin
               next_handler_act[i].send_remote = ~word[i].dir_transmit;
               next_handler_act[i].send_data   = word[i].dir_transmit;
            end
            if (rx_frame.valid && tag_match[i]) begin
               next_handler_act[i].store_frame =
                  ~word[i].dir_transmit & ~rx_frame.remote;
               next_handler_act[i].raise_pending =
                  word[i].dir_transmit & rx_frame.remote & auto_answer_enable[i];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         handler_act   <= '0;
         arb_to_ram    <= '0;
         object_tag    <= '0;
         object_active <= '0;
      end else begin
         handler_act   <= next_handler_act;
         arb_to_ram    <= next_arb_to_ram;
         object_tag    <= next_object_tag;
         object_active <= next_object_active;
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_one_wait : assert property (
      (access && !pready) |=> pready)
      else $error("apb answer not one wait state");

   a_apb_bad_addr : assert property (
      (access && !pready && !mapped) |=> (pready && pslverr))
      else $error("unmapped address without error");

   //------------------------------------------------------------
   // bus output shape
   //------------------------------------------------------------
   // read data must not leak outside the answer cycle
   a_rdata_idle : assert property (
      !pready |-> (prdata == RDATA_IDLE))
      else $error("read data outside answer cycle");

   a_err_with_ready : assert property (
      pslverr |-> pready)
      else $error("error flag without ready");

   a_ready_single : assert property (
      pready |=> !pready)
      else $error("ready held longer than one cycle");

   a_upper_zero : assert property (
      prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");

   generate
      for (g = 0; g < NUM_SETS; g++) begin : g_chk
         a_write_lands : assert property (
            bus_we[g] && !ram_load[g] |=> (word[g] == $past(pwdata[WORD_W-1:0])))
            else $error("bus write not stored");

         a_idle_quiet : assert property (
            !word[g].object_in_use_flag |=> (handler_act[g] == '0))
            else $error("unused object produced an action");

         a_remote_ask : assert property (
            (word[g].object_in_use_flag && send_pending_flag[g] && !word[g].dir_transmit)
            |=> (handler_act[g].send_remote && !handler_act[g].send_data))
            else $error("receive object did not request remote frame");

         a_data_send : assert property (
            (word[g].object_in_use_flag && send_pending_flag[g] && word[g].dir_transmit)
            |=> (handler_act[g].send_data && !handler_act[g].send_remote))
            else $error("transmit object did not send data");

         a_store_rx : assert property (
            (word[g].object_in_use_flag && rx_frame.valid && !rx_frame.remote
             && tag_match[g] && !word[g].dir_transmit) |=> handler_act[g].store_frame)
            else $error("matching data frame not stored");

         a_answer_gate : assert property (
            (rx_frame.valid && rx_frame.remote && !auto_answer_enable[g])
            |=> !handler_act[g].raise_pending)
            else $error("pending raised with auto answer off");

         a_answer_set : assert property (
            (word[g].object_in_use_flag && word[g].dir_transmit && rx_frame.valid
             && rx_frame.remote && tag_match[g] && auto_answer_enable[g])
            |=> handler_act[g].raise_pending)
            else $error("matching remote frame not answered");

         a_std_low_zero : assert property (
            !word[g].long_tag_select |=> (object_tag[g][17:0] == 18'h00000))
            else $error("standard tag low bits not ignored");

         a_ext_upper : assert property (
            word[g].long_tag_select
            |=> (object_tag[g][28:16] == $past(word[g].arbitration_tag_upper)))
            else $error("extended tag upper bits wrong");

         a_active_follow : assert property (
            object_active[g] == $past(word[g].object_in_use_flag))
            else $error("active output does not follow in use flag");

         a_read_value : assert property (
            (access && !pready && !pwrite && hit[g])
            |=> (prdata[15:0] == $past(word[g])))
            else $error("read data not the stored word");

         a_ram_wins : assert property (
            ram_load[g] |=> (word[g] == $past(ram_word[g])))
            else $error("ram load not stored");

         a_mirror_out : assert property (
            arb_to_ram[g] == $past(word[g]))
            else $error("ram copy does not follow word");

         a_ext_lower : assert property (
            word[g].long_tag_select
            |=> (object_tag[g][15:0] == $past(tag_lower[g])))
            else $error("extended tag lower bits wrong");

         a_std_upper : assert property (
            !word[g].long_tag_select
            |=> (object_tag[g][28:18]
                 == $past(word[g].arbitration_tag_upper[TAG_W-1:STD_SHIFT])))
            else $error("standard tag bits wrong");

         // a transmit object never keeps a received data frame
         a_no_store_tx : assert property (
            word[g].dir_transmit |=> !handler_act[g].store_frame)
            else $error("transmit object stored a frame");

         a_no_raise_rx : assert property (
            !word[g].dir_transmit |=> !handler_act[g].raise_pending)
            else $error("receive object raised pending");
      end
   endgenerate

endmodule : cma_arb_top

// ### hdl/cma_arb_word.sv
// one arbitration word register of an interface set
`timescale 1ns/1ps
module cma_arb_word (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              bus_we,
   input  wire cma_pkg::cma_arb_t bus_data,
   input  wire logic              ram_we,
   input  wire cma_pkg::cma_arb_t ram_data,
   output cma_pkg::cma_arb_t      word
);
   import cma_pkg::*;

   cma_arb_t next_word;

   //------------------------------------------------------------
   // word update
   //------------------------------------------------------------
   // ram transfer wins: it completes a command software already issued
   always_comb begin
      next_word = word;
      if (ram_we) begin
         next_word = ram_data;
      end else if (bus_we) begin
         next_word = bus_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word <= cma_arb_t'(ARB_RESET);
      end else begin
         word <= next_word;
      end
   end

endmodule : cma_arb_word

// ### inc/cma_pkg.sv
// constants and carriers for the message arbitration word block
//------------------------------------------------------------
// Contract
// - extended object: low 13 bits are identifier bits 28 down to 16
// - standard object: identifier is bits 28..18, bits 17 and 16 ignored
// - receive direction with send pending transmits a remote frame with this identifier
// - receive direction stores a matching received data frame into this object
// - transmit direction with send pending sends object contents as data frame
// - transmit direction, matching remote frame sets send pending if auto answer on
// - bit 14 selects format: 0 standard 11-bit, 1 extended 29-bit
// - object not in use: handler ignores it for transmit and receive
// - object in use: handler includes it in transmit and receive processing
// - word layout mirrors message ram object so transfers move fields unchanged
// - remote frame sets send pending only with auto answer, else unchanged
//------------------------------------------------------------
package cma_pkg;

   localparam int          NUM_SETS       = 2;
   localparam int          WORD_W         = 16;
   localparam int          TAG_W          = 13;
   localparam int          ID_W           = 29;
   localparam int          LOW_W          = 16;
   localparam logic [31:0] ADDR_IF1_ARB2  = 32'h4005_0034;
   localparam logic [31:0] ADDR_IF2_ARB2  = 32'h4005_0094;
   localparam int          POS_DIR        = 13;
   localparam int          POS_LONG       = 14;
   localparam int          POS_IN_USE     = 15;
   localparam int          STD_SHIFT      = 2;
   localparam logic [15:0] ARB_RESET      = 16'h0000;
   localparam logic [31:0] RDATA_IDLE     = 32'h0000_0000;

   // field order equals the ram object layout
   typedef struct packed {
      logic              object_in_use_flag;
      logic              long_tag_select;
      logic              dir_transmit;
      logic [TAG_W-1:0]  arbitration_tag_upper;
   } cma_arb_t;

   typedef struct packed {
      logic              valid;
      logic              remote;
      logic              long_tag;
      logic [ID_W-1:0]   tag;
   } cma_rx_t;

   typedef struct packed {
      logic              send_remote;
      logic              send_data;
      logic              store_frame;
      logic              raise_pending;
   } cma_act_t;

endpackage : cma_pkg

// ### verification/cma_arb_top_test.sv
// self-checking bench for the arbitration word block
`timescale 1ns/1ps
module cma_arb_top_test;
   import cma_pkg::*;
   logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0]                   paddr, pwdata, prdata, rd;
   logic [NUM_SETS-1:0]           ram_load, pend, auto, object_active;
   cma_arb_t [NUM_SETS-1:0]       ram_word, arb_to_ram;
   logic [NUM_SETS-1:0][15:0]     tag_lower;
   logic [NUM_SETS-1:0][28:0]     object_tag;
   cma_rx_t                       rx_frame;
   cma_act_t [NUM_SETS-1:0]       handler_act;
   int                            error_cnt, num_checks, cycles;

   cma_arb_top cma_arb_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ram_load(ram_load), .ram_word(ram_word),
      .tag_lower(tag_lower), .send_pending_flag(pend), .auto_answer_enable(auto),
      .rx_frame(rx_frame), .arb_to_ram(arb_to_ram), .object_tag(object_tag),
      .object_active(object_active), .handler_act(handler_act));
   cma_far_model cma_far_model_inst (.pclk(pclk), .rx_frame(rx_frame),
      .ram_load(ram_load), .ram_word(ram_word));

   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         conclude();
      end
   end
   //------------------------------------------------------------
   // tasks
   //------------------------------------------------------------
   task automatic conclude();
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // entered just after a rising edge; pready sampled at the rising edge only
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] e, input logic f);
      apb(1'b0, a, 32'h0);
      chk(what, rd, e);
      chk("slverr", {31'h0, err}, {31'h0, f});
   endtask : rdc
   // one cycle for the input to be taken, then look at the registered answer
   task automatic look();
      @(posedge pclk);
      @(negedge pclk);
   endtask : look
   //------------------------------------------------------------
   // sequence
   //------------------------------------------------------------
   initial begin
      pclk = 0;
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      pend = 0;
      auto = 0;
      tag_lower = {16'h0003, 16'h5a3c};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc("set1", ADDR_IF1_ARB2, 32'h0, 1'b0);
      rdc("set2", ADDR_IF2_ARB2, 32'h0, 1'b0);
      rdc("hole", 32'h4005_0038, 32'h0, 1'b1);
      // unused set kept out of use before leaving initialisation
      apb(1'b1, ADDR_IF2_ARB2, 32'h0000_0000);
      chk("active1", object_active[1], 32'h0);
      // out of use while configuring, then enable
      apb(1'b1, ADDR_IF1_ARB2, 32'hffff_5abc);
      apb(1'b1, ADDR_IF1_ARB2, 32'hffff_dabc);
      rdc("set1", ADDR_IF1_ARB2, 32'h0000_dabc, 1'b0);
      rdc("set2", ADDR_IF2_ARB2, 32'h0, 1'b0);
      chk("tag0", object_tag[0], {13'h1abc, 16'h5a3c});
      chk("active0", object_active[0], 32'h1);
      pend[0] <= 1'b1;
      look();
      chk("act0", handler_act[0], 32'h8);
      @(posedge pclk);
      pend[0] <= 1'b0;
      cma_far_model_inst.send(1'b0, 1'b1, {13'h1abc, 16'h5a3c});
      @(negedge pclk);
      chk("act0", handler_act[0], 32'h2);
      @(posedge pclk);
      apb(1'b1, ADDR_IF2_ARB2, 32'h2aa5);
      apb(1'b1, ADDR_IF2_ARB2, 32'haaa5);
      pend[1] <= 1'b1;
      auto[1] <= 1'b1;
      look();
      chk("tag1", object_tag[1], {11'h2a9, 18'h0});
      chk("act1", handler_act[1], 32'h4);
      // bits 17:0 of the frame set on purpose: a standard match ignores them
      @(posedge pclk);
      cma_far_model_inst.send(1'b1, 1'b0, {11'h2a9, 18'h3ffff});
      @(negedge pclk);
      chk("act1", handler_act[1], 32'h5);
      @(posedge pclk);
      auto[1] <= 1'b0;
      @(posedge pclk);
      cma_far_model_inst.send(1'b1, 1'b0, {11'h2a9, 18'h0});
      @(negedge pclk);
      chk("act1", handler_act[1], 32'h4);
      @(posedge pclk);
      auto[1] <= 1'b1;
      @(posedge pclk);
      cma_far_model_inst.send(1'b1, 1'b1, {11'h2a9, 18'h0});
      @(negedge pclk);
      chk("act1", handler_act[1], 32'h4);
      @(posedge pclk);
      apb(1'b1, ADDR_IF2_ARB2, 32'h2aa5);
      cma_far_model_inst.send(1'b1, 1'b0, {11'h2a9, 18'h0});
      @(negedge pclk);
      chk("act1", handler_act[1], 32'h0);
      chk("active1", object_active[1], 32'h0);
      @(posedge pclk);
      cma_far_model_inst.load(0, 16'h8123);
      look();
      chk("to_ram0", arb_to_ram[0], 32'h8123);
      @(posedge pclk);
      rdc("set1", ADDR_IF1_ARB2, 32'h0000_8123, 1'b0);
      conclude();
   end
endmodule : cma_arb_top_test

// ### verification/cma_far_model.sv
// far-side model: frames from remote nodes and loads from message ram
`timescale 1ns/1ps
module cma_far_model (
   input  wire logic                                 pclk,
   output cma_pkg::cma_rx_t                          rx_frame,
   output logic [cma_pkg::NUM_SETS-1:0]              ram_load,
   output cma_pkg::cma_arb_t [cma_pkg::NUM_SETS-1:0] ram_word
);
   import cma_pkg::*;
   initial begin
      rx_frame = '0;
      ram_load = '0;
      ram_word = '0;
   end
   //------------------------------------------------------------
   // frames
   //------------------------------------------------------------
   // lines scramble after a frame, so a stale id can never match
   task automatic send(input logic rmt, input logic lng, input logic [28:0] tag);
      rx_frame <= '{valid: 1'b1, remote: rmt, long_tag: lng, tag: tag};
      @(posedge pclk);
      rx_frame <= '{valid: 1'b0, remote: ~rmt, long_tag: ~lng, tag: ~tag};
   endtask : send
   task automatic load(input int s, input logic [15:0] w);
      ram_load[s] <= 1'b1;
      ram_word[s] <= w;
      @(posedge pclk);
      ram_load[s] <= 1'b0;
      ram_word[s] <= ~w;
   endtask : load
endmodule : cma_far_model
